// ==== rtl/mcu8_instruction_execute.v ====
// Purpose: execute stage of a small 8-bit accumulator core
// Assumes: decoded instruction fields arrive on ports; program memory reads combinationally
// Notes: register page, control page, aux page and stack are flip-flop arrays
// Operation
// RULE1 - Fixed 55-instruction set, mostly single cycle; the opcode map here defines 53 (0x00-0x34)
// RULE2 - Destination select 0 writes accumulator
// RULE3 - Destination select 1 writes register back
// RULE4 - Carry set on add carry, no borrow
// RULE5 - Carry cleared on no carry, borrow
// RULE6 - Register subtract adds complemented accumulator
// RULE7 - Immediate subtract always writes accumulator
// RULE8 - Bit test skips, no flags changed
// RULE9 - Increment/decrement skip on zero, flags kept
// RULE10 - Decimal adjust touches only carry
// RULE11 - Halt enters halt, clears powerdown flag
// RULE12 - Timeout flag set by reset, clear, halt
// RULE13 - Watchdog timeout clears timeout flag
// RULE14 - Powerdown flag set by reset, watchdog clear
// RULE15 - Interrupt return pops, enables interrupts, two cycles
// RULE16 - Plain return pops, two cycles, no flags
// RULE17 - Literal return loads accumulator, two cycles
// RULE18 - Computed branch/call use accumulator plus buffer
// RULE19 - Table read stores high byte, two cycles
// RULE20 - Register page 0x0-0x7F, bit 0-7
// RULE21 - Control page only 0x5-0xF, no flags
// RULE22 - Aux page 0x0-0x15, no flags
// RULE23 - Wake with interrupts on vectors to 0x008
// RULE24 - Skipped instruction executes as no-operation
// RULE25 - Logic ops set zero only
//
// Implementation choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "mcu8_consts.vh"
module mcu8_instruction_execute #(
	parameter PC_WIDTH = 11,
	parameter ROM_WIDTH = 14,
	parameter STACK_DEPTH = 8
) (
	input wire clk,
	input wire reset,
	input wire instrValid,
	input wire [5:0] instrOp,
	input wire [6:0] instrReg,
	input wire [2:0] instrBit,
	input wire instrDest,
	input wire [7:0] instrImm,
	input wire [PC_WIDTH-1:0] instrAddr,
	input wire [ROM_WIDTH-1:0] romData,
	input wire wdtTimeout,
	input wire wakePin,
	input wire [3:0] busAddr,
	input wire [7:0] busWrData,
	input wire busWr,
	input wire busRd,
	output reg [7:0] busRdData_q,
	output reg instrReady_q,
	output reg [PC_WIDTH-1:0] pc_q,
	output reg [PC_WIDTH-1:0] romAddr_q,
	output reg romRd_q,
	output reg haltMode_q,
	output reg wdtClear_q,
	output reg intEnable_q
);
	localparam SP_W = $clog2(STACK_DEPTH);
	localparam [15:0] resetVector = `RESET_VECTOR;
	localparam [15:0] wakeVector = `WAKE_VECTOR;

	reg [7:0] regFile [0:127];
	reg [7:0] ctlPage [0:15];
	reg [7:0] auxPage [0:`AUX_PAGE_SIZE-1];
	reg [PC_WIDTH-1:0] stack [0:STACK_DEPTH-1];
	reg [7:0] timer0Mode;
	reg [7:0] accumulator_q;
	reg carryFlag_q;
	reg digitCarry_q;
	reg zeroFlag_q;
	reg timeoutFlagN_q;
	reg powerdownFlagN_q;
	reg skip_q;
	reg [1:0] busyCnt_q;
	reg tablePending_q;
	reg [SP_W-1:0] sp_q;
	reg [7:0] ctrl_q;
	reg [7:0] tblPtr_q;
	reg [7:0] pcHighBuf_q;
	reg [7:0] tableHigh_q;
	reg wakeS1_q;
	reg wakeS2_q;
	reg wakeS3_q;
	reg wakeLevel_q;

	// ----------------------------------------
	// Operand and ALU
	// ----------------------------------------
	reg [7:0] regVal;
	reg [7:0] addA;
	reg [7:0] addB;
	reg addCin;
	reg [4:0] lowSum;
	reg [8:0] fullSum;
	reg [7:0] bitMask;
	reg [7:0] daaAdj;
	reg [8:0] daaSum;
	reg daaHigh;
	reg [7:0] res;
	reg wrReg;
	reg wrAcc;
	reg updZ;
	reg updC;
	reg updDc;
	reg newC;
	reg skipHit;
	reg ctlOk;
	reg auxOk;
	wire runEnable = ctrl_q[`CTRL_RUN_BIT];
	wire instrTaken = instrValid & instrReady_q & ~haltMode_q;
	wire exec = instrTaken & ~skip_q;
	wire [PC_WIDTH-1:0] pcPlus = pc_q + {{(PC_WIDTH-1){1'b0}}, 1'b1};
	wire [PC_WIDTH-1:0] accTarget = {pcHighBuf_q[PC_WIDTH-9:0], accumulator_q};
	wire isCall = (instrOp == `OP_CALL_ACC) | (instrOp == `OP_LONG_CALL) | (instrOp == `OP_SW_INT);
	wire wakeVec = haltMode_q & (wakeLevel_q | wdtTimeout) & intEnable_q;
	wire pushEn = (exec & isCall) | wakeVec;
	wire [PC_WIDTH-1:0] pushData = wakeVec ? pc_q : pcPlus;

	always @*
	begin
		regVal = regFile[instrReg];
		// RULE6 carry forms add carry, plain subtracts and compare add one, plain adds add zero
		addA = (instrOp >= `OP_ADD_IM && instrOp <= `OP_SBC_IM) ? instrImm : regVal;
		addB = (instrOp == `OP_SUB_AR || instrOp == `OP_SBC_AR || instrOp == `OP_SUB_IM ||
			instrOp == `OP_SBC_IM || instrOp == `OP_CMP) ? ~accumulator_q : accumulator_q;
		if (instrOp == `OP_ADC_AR || instrOp == `OP_SBC_AR || instrOp == `OP_ADC_IM ||
			instrOp == `OP_SBC_IM)
			addCin = carryFlag_q;
		else
			addCin = (instrOp == `OP_SUB_AR || instrOp == `OP_SUB_IM || instrOp == `OP_CMP);
		lowSum = {1'b0, addA[3:0]} + {1'b0, addB[3:0]} + {4'h0, addCin};
		fullSum = {1'b0, addA} + {1'b0, addB} + {8'h00, addCin};
		// RULE20 bit operand picks one of eight bits
		bitMask = 8'h01 << instrBit;
		daaHigh = carryFlag_q | (accumulator_q[7:4] > `BCD_DIGIT_MAX) |
			((accumulator_q[7:4] == `BCD_DIGIT_MAX) & (accumulator_q[3:0] > `BCD_DIGIT_MAX));
		daaAdj[3:0] = (digitCarry_q | (accumulator_q[3:0] > `BCD_DIGIT_MAX)) ? `BCD_FIX : 4'h0;
		daaAdj[7:4] = daaHigh ? `BCD_FIX : 4'h0;
		daaSum = {1'b0, accumulator_q} + {1'b0, daaAdj};
		ctlOk = (instrReg[3:0] >= `CTL_PAGE_LO) & (instrReg[6:4] == 3'h0);
		auxOk = (instrReg[4:0] <= `AUX_PAGE_HI) & (instrReg[6:5] == 2'h0);
		res = 8'h00;
		wrReg = 1'b0;
		wrAcc = 1'b0;
		updZ = 1'b0;
		updC = 1'b0;
		updDc = 1'b0;
		newC = fullSum[8];
		skipHit = 1'b0;
		case (instrOp)
			// RULE25 logic ops move only zero
			`OP_AND_AR, `OP_AND_IM: res = accumulator_q & ((instrOp == `OP_AND_IM) ? instrImm : regVal);
			`OP_OR_AR, `OP_OR_IM: res = accumulator_q | ((instrOp == `OP_OR_IM) ? instrImm : regVal);
			`OP_XOR_AR, `OP_XOR_IM: res = accumulator_q ^ ((instrOp == `OP_XOR_IM) ? instrImm : regVal);
			`OP_ROT_R:
			begin
				res = {carryFlag_q, regVal[7:1]};
				newC = regVal[0];
			end
			`OP_ROT_L:
			begin
				res = {regVal[6:0], carryFlag_q};
				newC = regVal[7];
			end
			`OP_BIT_SET: res = regVal | bitMask;
			`OP_BIT_CLR: res = regVal & ~bitMask;
			`OP_INC, `OP_INC_SZ: res = regVal + 8'h01;
			`OP_DEC, `OP_DEC_SZ: res = regVal - 8'h01;
			`OP_COM: res = ~regVal;
			`OP_STORE_ACC, `OP_WR_CTL, `OP_WR_AUX, `OP_WR_T0: res = accumulator_q;
			`OP_MOVE_REG: res = regVal;
			`OP_LOAD_IMM, `OP_RET_LIT: res = instrImm;
			`OP_SWAP: res = {regVal[3:0], regVal[7:4]};
			// RULE21 control page reads outside 0x5-0xF give zero
			`OP_RD_CTL: res = ctlOk ? ctlPage[instrReg[3:0]] : 8'h00;
			// RULE22 aux page reads outside 0x0-0x15 give zero
			`OP_RD_AUX: res = auxOk ? auxPage[instrReg[4:0]] : 8'h00;
			`OP_RD_T0: res = timer0Mode;
			`OP_DAA:
			begin
				res = daaSum[7:0];
				newC = daaHigh | daaSum[8];
			end
			default: res = fullSum[7:0];
		endcase
		case (instrOp)
			// RULE2 select 0 goes to the accumulator
			// RULE3 select 1 goes back to the register
			`OP_AND_AR, `OP_OR_AR, `OP_XOR_AR, `OP_INC, `OP_DEC, `OP_COM, `OP_MOVE_REG:
			begin
				wrReg = instrDest;
				wrAcc = ~instrDest;
				updZ = 1'b1;
			end
			`OP_AND_IM, `OP_OR_IM, `OP_XOR_IM:
			begin
				wrAcc = 1'b1;
				updZ = 1'b1;
			end
			`OP_ROT_R, `OP_ROT_L:
			begin
				wrReg = instrDest;
				wrAcc = ~instrDest;
				updC = 1'b1;
			end
			`OP_SWAP:
			begin
				wrReg = instrDest;
				wrAcc = ~instrDest;
			end
			`OP_BIT_SET, `OP_BIT_CLR, `OP_STORE_ACC: wrReg = 1'b1;
			// RULE8 test skips without touching flags
			`OP_TST_CLR: skipHit = ~|(regVal & bitMask);
			`OP_TST_SET: skipHit = |(regVal & bitMask);
			// RULE9 skip on zero result, flags kept
			`OP_INC_SZ, `OP_DEC_SZ:
			begin
				wrReg = instrDest;
				wrAcc = ~instrDest;
				skipHit = (res == 8'h00);
			end
			`OP_LOAD_IMM, `OP_RD_CTL, `OP_RD_AUX, `OP_RD_T0, `OP_RET_LIT: wrAcc = 1'b1;
			// RULE4 carry out or no borrow sets carry
			// RULE5 no carry or borrow clears carry
			`OP_ADD_AR, `OP_SUB_AR, `OP_ADC_AR, `OP_SBC_AR:
			begin
				wrReg = instrDest;
				wrAcc = ~instrDest;
				updZ = 1'b1;
				updC = 1'b1;
				updDc = 1'b1;
			end
			// RULE7 immediate forms always land in the accumulator
			`OP_ADD_IM, `OP_SUB_IM, `OP_ADC_IM, `OP_SBC_IM:
			begin
				wrAcc = 1'b1;
				updZ = 1'b1;
				updC = 1'b1;
				updDc = 1'b1;
			end
			// RULE10 only carry follows the adjustment
			`OP_DAA:
			begin
				wrAcc = 1'b1;
				updC = 1'b1;
			end
			`OP_CMP:
			begin
				updZ = 1'b1;
				updC = 1'b1;
			end
			`OP_CLR_ACC:
			begin
				res = 8'h00;
				wrAcc = 1'b1;
				updZ = 1'b1;
			end
			`OP_CLR_REG:
			begin
				res = 8'h00;
				wrReg = 1'b1;
				updZ = 1'b1;
			end
			default: wrReg = 1'b0;
		endcase
	end

	// ----------------------------------------
	// Storage arrays
	// ----------------------------------------
	// Data storage has no reset, so its content is undefined after power-up
	always @(posedge clk)
	begin
		// RULE20 register page index is seven bits wide
		if (exec && wrReg)
			regFile[instrReg] <= res;
		// RULE21 writes outside the control page are dropped
		if (exec && instrOp == `OP_WR_CTL && ctlOk)
			ctlPage[instrReg[3:0]] <= res;
		// RULE22 aux page writes in one cycle
		if (exec && instrOp == `OP_WR_AUX && auxOk)
			auxPage[instrReg[4:0]] <= res;
		if (exec && instrOp == `OP_WR_T0)
			timer0Mode <= res;
		if (pushEn)
			stack[sp_q] <= pushData;
	end

	// ----------------------------------------
	// Wake pin synchroniser
	// ----------------------------------------
	always @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			wakeS1_q <= 1'b0;
			wakeS2_q <= 1'b0;
			wakeS3_q <= 1'b0;
			wakeLevel_q <= 1'b0;
		end
		else
		begin
			wakeS1_q <= wakePin;
			wakeS2_q <= wakeS1_q;
			wakeS3_q <= wakeS2_q;
			if (wakeS2_q == wakeS3_q)
				wakeLevel_q <= wakeS3_q;
		end
	end

	// ----------------------------------------
	// Sequencer, flags and register port
	// ----------------------------------------
	always @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			busRdData_q <= 8'h00;
			instrReady_q <= 1'b0;
			pc_q <= resetVector[PC_WIDTH-1:0];
			romAddr_q <= resetVector[PC_WIDTH-1:0];
			romRd_q <= 1'b0;
			haltMode_q <= 1'b0;
			wdtClear_q <= 1'b0;
			intEnable_q <= 1'b0;
			accumulator_q <= 8'h00;
			carryFlag_q <= 1'b0;
			digitCarry_q <= 1'b0;
			zeroFlag_q <= 1'b0;
			// RULE12 timeout flag reads one after power-up
			timeoutFlagN_q <= 1'b1;
			// RULE14 powerdown flag reads one after power-up
			powerdownFlagN_q <= 1'b1;
			skip_q <= 1'b0;
			busyCnt_q <= 2'h0;
			tablePending_q <= 1'b0;
			sp_q <= {SP_W{1'b0}};
			ctrl_q <= `CTRL_RESET;
			tblPtr_q <= 8'h00;
			pcHighBuf_q <= 8'h00;
			tableHigh_q <= 8'h00;
		end
		else
		begin
			wdtClear_q <= 1'b0;
			romRd_q <= 1'b0;
			instrReady_q <= runEnable;
			busRdData_q <= 8'h00;
			if (busRd)
			begin
				case (busAddr)
					`ADDR_STATUS: busRdData_q <= {1'b0, haltMode_q, intEnable_q, timeoutFlagN_q,
						powerdownFlagN_q, zeroFlag_q, digitCarry_q, carryFlag_q};
					`ADDR_ACC: busRdData_q <= accumulator_q;
					`ADDR_TBL_HIGH: busRdData_q <= tableHigh_q;
					`ADDR_CTRL: busRdData_q <= ctrl_q;
					`ADDR_TBL_PTR: busRdData_q <= tblPtr_q;
					`ADDR_PC_HIGH: busRdData_q <= pcHighBuf_q;
					default: busRdData_q <= 8'h00;
				endcase
			end
			if (busWr && busAddr == `ADDR_CTRL)
				ctrl_q <= busWrData;
			if (busWr && busAddr == `ADDR_TBL_PTR)
				tblPtr_q <= busWrData;
			if (busWr && busAddr == `ADDR_PC_HIGH)
				pcHighBuf_q <= busWrData;
			if (haltMode_q)
			begin
				if (wakeLevel_q || wdtTimeout)
				begin
					haltMode_q <= 1'b0;
					// RULE23 wake with interrupts on enters the service vector
					if (intEnable_q)
					begin
						sp_q <= sp_q + {{(SP_W-1){1'b0}}, 1'b1};
						pc_q <= wakeVector[PC_WIDTH-1:0];
						intEnable_q <= 1'b0;
					end
				end
				else
					instrReady_q <= 1'b0;
			end
			else if (busyCnt_q != 2'h0)
			begin
				busyCnt_q <= busyCnt_q - 2'h1;
				if (busyCnt_q != `EXTRA_CYC2)
					instrReady_q <= 1'b0;
				// RULE19 high byte held, low byte to accumulator
				if (busyCnt_q == `EXTRA_CYC2 && tablePending_q)
				begin
					tablePending_q <= 1'b0;
					tableHigh_q <= {{(16-ROM_WIDTH){1'b0}}, romData[ROM_WIDTH-1:8]};
					accumulator_q <= romData[7:0];
				end
			end
			else if (instrTaken)
			begin
				pc_q <= pcPlus;
				// RULE24 the skipped instruction only spends its cycle
				if (skip_q)
					skip_q <= 1'b0;
				else
				begin
					skip_q <= skipHit;
					if (wrAcc)
						accumulator_q <= res;
					if (updZ)
						zeroFlag_q <= (res == 8'h00);
					if (updC)
						carryFlag_q <= newC;
					if (updDc)
						digitCarry_q <= lowSum[4];
					// RULE1 one cycle unless an extra count is loaded
					case (instrOp)
						`OP_TABLE:
						begin
							romAddr_q <= {tblPtr_q[PC_WIDTH-9:0], accumulator_q};
							romRd_q <= 1'b1;
							tablePending_q <= 1'b1;
							busyCnt_q <= `EXTRA_CYC2;
							instrReady_q <= 1'b0;
						end
						// RULE11 halt clears powerdown flag
						`OP_SLEEP:
						begin
							haltMode_q <= 1'b1;
							powerdownFlagN_q <= 1'b0;
							timeoutFlagN_q <= 1'b1;
							wdtClear_q <= 1'b1;
							instrReady_q <= 1'b0;
						end
						// RULE14 watchdog clear restores powerdown flag
						`OP_WDT_CLR:
						begin
							powerdownFlagN_q <= 1'b1;
							timeoutFlagN_q <= 1'b1;
							wdtClear_q <= 1'b1;
						end
						`OP_INT_ON: intEnable_q <= 1'b1;
						`OP_INT_OFF: intEnable_q <= 1'b0;
						`OP_SW_INT:
						begin
							sp_q <= sp_q + {{(SP_W-1){1'b0}}, 1'b1};
							pc_q <= wakeVector[PC_WIDTH-1:0];
							intEnable_q <= 1'b0;
							busyCnt_q <= `EXTRA_CYC3;
							instrReady_q <= 1'b0;
						end
						// RULE15 return and re-enable interrupts
						// RULE16 plain return pops only
						// RULE17 literal lands through the accumulator path
						`OP_RET, `OP_RET_IRQ, `OP_RET_LIT:
						begin
							sp_q <= sp_q - {{(SP_W-1){1'b0}}, 1'b1};
							pc_q <= stack[sp_q - {{(SP_W-1){1'b0}}, 1'b1}];
							if (instrOp == `OP_RET_IRQ)
								intEnable_q <= 1'b1;
							busyCnt_q <= `EXTRA_CYC2;
							instrReady_q <= 1'b0;
						end
						// RULE18 computed forms target buffer high plus accumulator low, long forms the address field
						`OP_CALL_ACC, `OP_GOTO_ACC, `OP_LONG_CALL, `OP_LONG_BRANCH:
						begin
							if (instrOp == `OP_CALL_ACC || instrOp == `OP_LONG_CALL)
								sp_q <= sp_q + {{(SP_W-1){1'b0}}, 1'b1};
							if (instrOp == `OP_CALL_ACC || instrOp == `OP_GOTO_ACC)
								pc_q <= accTarget;
							else
								pc_q <= instrAddr;
							busyCnt_q <= `EXTRA_CYC2;
							instrReady_q <= 1'b0;
						end
						default: busyCnt_q <= 2'h0;
					endcase
				end
			end
			// RULE13 a watchdog timeout wins over a same-cycle set
			if (wdtTimeout)
				timeoutFlagN_q <= 1'b0;
		end
	end
endmodule

// ==== rtl/mcu8_consts.vh ====
// Purpose: shared constants of the 8-bit instruction execute core
// Assumes: included by its bare name
// Notes: opcode values are the decoder-side encoding of this core
`ifndef MCU8_CONSTS_VH
`define MCU8_CONSTS_VH
// ----------------------------------------
// Opcodes
// ----------------------------------------
`define OP_AND_AR 6'h00
`define OP_OR_AR 6'h01
`define OP_XOR_AR 6'h02
`define OP_AND_IM 6'h03
`define OP_OR_IM 6'h04
`define OP_XOR_IM 6'h05
`define OP_ROT_R 6'h06
`define OP_ROT_L 6'h07
`define OP_BIT_SET 6'h08
`define OP_BIT_CLR 6'h09
`define OP_INC 6'h0A
`define OP_DEC 6'h0B
`define OP_COM 6'h0C
`define OP_TST_CLR 6'h0D
`define OP_TST_SET 6'h0E
`define OP_INC_SZ 6'h0F
`define OP_DEC_SZ 6'h10
`define OP_STORE_ACC 6'h11
`define OP_MOVE_REG 6'h12
`define OP_LOAD_IMM 6'h13
`define OP_SWAP 6'h14
`define OP_WR_CTL 6'h15
`define OP_RD_CTL 6'h16
`define OP_WR_AUX 6'h17
`define OP_RD_AUX 6'h18
`define OP_WR_T0 6'h19
`define OP_RD_T0 6'h1A
`define OP_TABLE 6'h1B
`define OP_ADD_AR 6'h1C
`define OP_SUB_AR 6'h1D
`define OP_ADC_AR 6'h1E
`define OP_SBC_AR 6'h1F
`define OP_ADD_IM 6'h20
`define OP_SUB_IM 6'h21
`define OP_ADC_IM 6'h22
`define OP_SBC_IM 6'h23
`define OP_DAA 6'h24
`define OP_CMP 6'h25
`define OP_CLR_ACC 6'h26
`define OP_CLR_REG 6'h27
`define OP_NOP 6'h28
`define OP_SLEEP 6'h29
`define OP_WDT_CLR 6'h2A
`define OP_INT_ON 6'h2B
`define OP_INT_OFF 6'h2C
`define OP_SW_INT 6'h2D
`define OP_RET 6'h2E
`define OP_RET_IRQ 6'h2F
`define OP_RET_LIT 6'h30
`define OP_CALL_ACC 6'h31
`define OP_GOTO_ACC 6'h32
`define OP_LONG_CALL 6'h33
`define OP_LONG_BRANCH 6'h34
// ----------------------------------------
// Register port map and fields
// ----------------------------------------
`define ADDR_STATUS 4'h0
`define ADDR_ACC 4'h1
`define ADDR_TBL_HIGH 4'h2
`define ADDR_CTRL 4'h3
`define ADDR_TBL_PTR 4'h4
`define ADDR_PC_HIGH 4'h5
`define CTRL_RUN_BIT 0
`define CTRL_RESET 8'h01
`define ST_C 0
`define ST_DC 1
`define ST_Z 2
`define ST_PD_N 3
`define ST_TO_N 4
`define ST_INT_EN 5
`define ST_HALT 6
// ----------------------------------------
// Pages, vectors, arithmetic constants
// ----------------------------------------
`define CTL_PAGE_LO 4'h5
`define AUX_PAGE_HI 5'h15
`define AUX_PAGE_SIZE 22
`define RESET_VECTOR 16'h0000
`define WAKE_VECTOR 16'h0008
`define BCD_DIGIT_MAX 4'h9
`define BCD_FIX 4'h6
`define EXTRA_CYC2 2'h1
`define EXTRA_CYC3 2'h2
`endif

// ==== dv/mcu8_instruction_execute_asserts.sv ====
// Purpose: port-level property checks on the execute core
// Assumes: one clock, reset asynchronous and active high
// Notes: attached to every core instance by the bind at the foot
`timescale 1ns/1ps
`include "mcu8_consts.vh"
module mcu8_instruction_execute_asserts #(
	parameter PC_WIDTH = 11
) (
	input logic clk,
	input logic reset,
	input logic instrValid,
	input logic [5:0] instrOp,
	input logic busWr,
	input logic wakePin,
	input logic wdtTimeout,
	input logic instrReady_q,
	input logic [PC_WIDTH-1:0] pc_q,
	input logic romRd_q,
	input logic haltMode_q,
	input logic wdtClear_q,
	input logic intEnable_q
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	wire takenRaw = instrValid && instrReady_q && !haltMode_q;
	logic afterTest_q;
	// The slot after a test-and-skip may be discarded, so it is left unchecked
	always @(posedge clk or posedge reset)
	begin
		if (reset)
			afterTest_q <= 1'h0;
		else if (takenRaw)
			afterTest_q <= instrOp inside {`OP_TST_CLR, `OP_TST_SET, `OP_INC_SZ, `OP_DEC_SZ};
	end
	wire taken = takenRaw && !afterTest_q;
	// --------
	// Cycle counts, table strobe and interrupt return
	// --------
	a_one_cycle: assert property (taken && !busWr && instrOp inside {`OP_LOAD_IMM,
		`OP_ADD_AR, `OP_SUB_IM, `OP_AND_IM} |=> instrReady_q)
		else $error("single cycle op stalled");
	a_ret_two: assert property (taken &&
		instrOp inside {`OP_RET, `OP_RET_LIT, `OP_RET_IRQ} |=> !instrReady_q ##1 instrReady_q)
		else $error("return not two cycles");
	a_jump_two: assert property (taken && instrOp inside {`OP_GOTO_ACC, `OP_CALL_ACC}
		|=> !instrReady_q ##1 instrReady_q)
		else $error("computed jump not two cycles");
	a_table_rd: assert property (taken && instrOp == `OP_TABLE
		|=> romRd_q && !instrReady_q ##1 !romRd_q && instrReady_q)
		else $error("table read strobe wrong");
	a_irq_return: assert property (taken && instrOp == `OP_RET_IRQ |=> intEnable_q)
		else $error("interrupt return left interrupts off");
	// --------
	// Halt and wake
	// --------
	a_sleep_halt: assert property (taken && instrOp == `OP_SLEEP
		|=> haltMode_q && wdtClear_q)
		else $error("sleep did not halt");
	a_clear_wdt: assert property (taken && instrOp == `OP_WDT_CLR |=> wdtClear_q)
		else $error("watchdog clear not issued");
	a_halt_stall: assert property (haltMode_q |-> !instrReady_q)
		else $error("ready while halted");
	a_wdt_wake: assert property (haltMode_q && wdtTimeout |-> ##[1:2] !haltMode_q)
		else $error("timeout did not wake");
	a_pin_wake: assert property ($rose(wakePin) && haltMode_q |-> ##[1:8] !haltMode_q)
		else $error("wake pin ignored");
	a_wake_vector: assert property ($fell(haltMode_q) && $past(intEnable_q)
		|-> pc_q == 11'h008 && !intEnable_q)
		else $error("wake did not vector");
	c_table: cover property (taken && instrOp == `OP_TABLE);
	c_sleep: cover property (taken && instrOp == `OP_SLEEP);
	c_vector: cover property ($fell(haltMode_q) && $past(intEnable_q));
endmodule
bind mcu8_instruction_execute mcu8_instruction_execute_asserts #(.PC_WIDTH(PC_WIDTH)) checks (.*);

// ==== dv/rom_model.sv ====
// Purpose: program memory answering table reads
// Assumes: answers in the cycle the address is shown
// Notes: between reads the lines toggle so stale data never passes
`timescale 1ns/1ps
module rom_model (
	input logic clk,
	input logic [10:0] romAddr,
	input logic romRd,
	output logic [13:0] romData
);
	// --------
	// Contents
	// --------
	logic [13:0] junk = 14'h2AAA;
	always @(posedge clk)
		junk <= ~junk;
	assign romData = romRd ? {romAddr[10:5], romAddr[7:0] ^ 8'h5A} : junk;
endmodule

// ==== dv/mcu8_instruction_execute_test.sv ====
// Purpose: scenario bench for the execute core
// Assumes: one instruction presented at a time
// Notes: register page values are seen by moving them into the accumulator
`timescale 1ns/1ps
`include "mcu8_consts.vh"
module mcu8_instruction_execute_test;
	logic clk = 1'h0;
	logic reset = 1'h1;
	logic instrValid = 1'h0;
	logic [5:0] instrOp = '0;
	logic [6:0] instrReg = '0;
	logic [2:0] instrBit = '0;
	logic instrDest = 1'h0;
	logic [7:0] instrImm = '0;
	logic [10:0] instrAddr = '0;
	wire [13:0] romData;
	logic wdtTimeout = 1'h0;
	logic wakePin = 1'h0;
	logic [3:0] busAddr = '0;
	logic [7:0] busWrData = '0;
	logic busWr = 1'h0;
	logic busRd = 1'h0;
	wire [7:0] busRdData_q;
	wire instrReady_q, romRd_q, haltMode_q, wdtClear_q, intEnable_q;
	wire [10:0] pc_q, romAddr_q;
	int fails = 0;
	int checkCount = 0;
	always #5 clk = ~clk;
	mcu8_instruction_execute DUT (.*);
	rom_model pmem (.clk(clk), .romAddr(romAddr_q), .romRd(romRd_q), .romData(romData));
	// --------
	// Shared tasks
	// --------
	task automatic printVerdict;
		$display("checks %0d mismatches %0d", checkCount, fails);
		if (fails == 0 && checkCount > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input string what, input logic [10:0] exp, input logic [10:0] got);
		checkCount++;
		if (got !== exp)
		begin
			fails++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// Waits for ready first, so a stalled core never has a request dropped on it
	task automatic exec(input logic [5:0] op, input logic [6:0] r = '0,
		input logic [7:0] i = '0, input logic [2:0] b = '0, input logic d = '0,
		input logic [10:0] a = '0);
		int n;
		n = 0;
		while (instrReady_q !== 1'h1 && n < 20)
		begin
			tick(1);
			n++;
		end
		chk("ready", 1, instrReady_q);
		if (instrReady_q !== 1'h1)
			printVerdict();
		@(posedge clk);
		instrOp <= op;
		instrReg <= r;
		instrImm <= i;
		instrBit <= b;
		instrDest <= d;
		instrAddr <= a;
		instrValid <= 1'h1;
		@(posedge clk);
		instrValid <= 1'h0;
		#1;
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk);
		busWr <= 1'h1;
		busAddr <= a;
		busWrData <= v;
		@(posedge clk);
		busWr <= 1'h0;
		#1;
	endtask
	task automatic rd(input string what, input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk);
		busRd <= 1'h1;
		busAddr <= a;
		@(posedge clk);
		busRd <= 1'h0;
		#1;
		chk(what, exp, busRdData_q);
	endtask
	task automatic setReg(input logic [6:0] r, input logic [7:0] v);
		exec(`OP_LOAD_IMM, '0, v);
		exec(`OP_STORE_ACC, r);
	endtask
	task automatic regIs(input logic [6:0] r, input logic [7:0] v);
		exec(`OP_MOVE_REG, r);
		rd("register", `ADDR_ACC, v);
	endtask
	task automatic twoCycle(input logic [5:0] op, input logic [7:0] i = '0);
		exec(op, '0, i);
		chk("ready low", 0, instrReady_q);
		tick(1);
		chk("ready back", 1, instrReady_q);
	endtask
	task automatic waitWake;
		int n;
		n = 0;
		while (haltMode_q !== 1'h0 && n < 20)
		begin
			tick(1);
			n++;
		end
		chk("wake", 0, haltMode_q);
		if (haltMode_q !== 1'h0)
			printVerdict();
	endtask
	// --------
	// Scenarios
	// --------
	task automatic scnReset;
		rd("status", `ADDR_STATUS, 8'h18);
		rd("run bit", `ADDR_CTRL, `CTRL_RESET);
		rd("unmapped", 4'hF, 8'h00);
		wr(`ADDR_STATUS, 8'hFF);
		rd("status ro", `ADDR_STATUS, 8'h18);
	endtask
	task automatic scnAdd;
		setReg(7'h7F, 8'hF0);
		exec(`OP_LOAD_IMM, '0, 8'h20);
		exec(`OP_ADD_AR, 7'h7F);
		rd("add acc", `ADDR_ACC, 8'h10);
		rd("add flags", `ADDR_STATUS, 8'h19);
		regIs(7'h7F, 8'hF0);
		exec(`OP_LOAD_IMM, '0, 8'h0F);
		exec(`OP_ADD_AR, 7'h7F, '0, '0, 1'h1);
		rd("no carry", `ADDR_STATUS, 8'h18);
		rd("acc kept", `ADDR_ACC, 8'h0F);
		regIs(7'h7F, 8'hFF);
	endtask
	task automatic scnSub;
		setReg(7'h11, 8'h05);
		exec(`OP_LOAD_IMM, '0, 8'h07);
		exec(`OP_SUB_AR, 7'h11, '0, '0, 1'h1);
		rd("borrow", `ADDR_STATUS, 8'h18);
		regIs(7'h11, 8'hFE);
		exec(`OP_LOAD_IMM, '0, 8'h07);
		exec(`OP_SUB_IM, '0, 8'h09);
		rd("sub imm", `ADDR_ACC, 8'h02);
		rd("sub flags", `ADDR_STATUS, 8'h1B);
		exec(`OP_SBC_IM, '0, 8'h09);
		rd("sbc imm", `ADDR_ACC, 8'h07);
		exec(`OP_AND_IM, '0, 8'h00);
		rd("and zero", `ADDR_STATUS, 8'h1F);
	endtask
	task automatic scnSkip;
		setReg(7'h12, 8'h7F);
		exec(`OP_TST_SET, 7'h12, '0, 3'h7);
		exec(`OP_LOAD_IMM, '0, 8'h55);
		exec(`OP_TST_CLR, 7'h12, '0, 3'h7);
		exec(`OP_LOAD_IMM, '0, 8'h66);
		rd("bit skip", `ADDR_ACC, 8'h55);
		setReg(7'h13, 8'h02);
		exec(`OP_DEC_SZ, 7'h13, '0, '0, 1'h1);
		exec(`OP_LOAD_IMM, '0, 8'h77);
		exec(`OP_DEC_SZ, 7'h13, '0, '0, 1'h1);
		exec(`OP_LOAD_IMM, '0, 8'h88);
		rd("zero skip", `ADDR_ACC, 8'h77);
		rd("skip flags", `ADDR_STATUS, 8'h1F);
	endtask
	task automatic scnDaa;
		exec(`OP_LOAD_IMM, '0, 8'h99);
		exec(`OP_ADD_IM, '0, 8'h01);
		exec(`OP_DAA);
		rd("bcd", `ADDR_ACC, 8'h00);
		rd("bcd flags", `ADDR_STATUS, 8'h19);
	endtask
	task automatic scnFlow;
		logic [10:0] p;
		logic [5:0] rets [3] = '{`OP_RET, `OP_RET_LIT, `OP_RET_IRQ};
		wr(`ADDR_PC_HIGH, 8'h03);
		exec(`OP_LOAD_IMM, '0, 8'h44);
		twoCycle(`OP_GOTO_ACC);
		chk("branch", 11'h344, pc_q);
		for (int k = 0; k < 3; k++)
		begin
			p = pc_q;
			exec(`OP_LONG_CALL, '0, '0, '0, '0, 11'h100);
			chk("call", 11'h100, pc_q);
			twoCycle(rets[k], 8'h99);
			chk("return", p + 11'h001, pc_q);
		end
		rd("literal", `ADDR_ACC, 8'h99);
		rd("flow flags", `ADDR_STATUS, 8'h39);
		wr(`ADDR_TBL_PTR, 8'h02);
		exec(`OP_LOAD_IMM, '0, 8'h34);
		exec(`OP_TABLE);
		chk("rom strobe", 1, romRd_q);
		chk("rom addr", 11'h234, romAddr_q);
		tick(1);
		rd("table low", `ADDR_ACC, 8'h6E);
		rd("table high", `ADDR_TBL_HIGH, 8'h11);
	endtask
	task automatic scnPages;
		exec(`OP_LOAD_IMM, '0, 8'hA5);
		exec(`OP_WR_CTL, 7'h0F);
		exec(`OP_LOAD_IMM, '0, 8'h3C);
		exec(`OP_WR_AUX, 7'h15);
		exec(`OP_RD_CTL, 7'h0F);
		rd("control page", `ADDR_ACC, 8'hA5);
		exec(`OP_RD_AUX, 7'h15);
		rd("aux page", `ADDR_ACC, 8'h3C);
		rd("page flags", `ADDR_STATUS, 8'h39);
	endtask
	task automatic scnMore;
		setReg(7'h20, 8'h81);
		exec(`OP_ROT_L, 7'h20, '0, '0, 1'h1);
		exec(`OP_SWAP, 7'h20, '0, '0, 1'h1);
		exec(`OP_BIT_SET, 7'h20, '0, 3'h0);
		exec(`OP_BIT_CLR, 7'h20, '0, 3'h4);
		exec(`OP_COM, 7'h20, '0, '0, 1'h1);
		exec(`OP_INC, 7'h20, '0, '0, 1'h1);
		exec(`OP_WR_T0);
		exec(`OP_CLR_ACC);
		exec(`OP_RD_T0);
		rd("timer mode", `ADDR_ACC, 8'h81);
		exec(`OP_CMP, 7'h20);
		rd("compare", `ADDR_STATUS, 8'h39);
		regIs(7'h20, 8'hDF);
		twoCycle(`OP_CALL_ACC);
		chk("computed call", 11'h3DF, pc_q);
		exec(`OP_SW_INT);
		tick(1);
		chk("int stall", 0, instrReady_q);
		chk("int vector", 11'h008, pc_q);
		chk("int mask", 0, intEnable_q);
	endtask
	task automatic scnPower;
		logic [10:0] p;
		exec(`OP_INT_OFF);
		p = pc_q;
		exec(`OP_SLEEP);
		chk("halt", 1, haltMode_q);
		chk("wdt clear", 1, wdtClear_q);
		rd("sleep flags", `ADDR_STATUS, 8'h51);
		@(posedge clk);
		wakePin <= 1'h1;
		waitWake();
		@(posedge clk);
		wakePin <= 1'h0;
		#1;
		chk("resume", p + 11'h001, pc_q);
		exec(`OP_INT_ON);
		exec(`OP_SLEEP);
		@(posedge clk);
		wdtTimeout <= 1'h1;
		@(posedge clk);
		wdtTimeout <= 1'h0;
		waitWake();
		chk("vector", 11'h008, pc_q);
		rd("timeout flags", `ADDR_STATUS, 8'h01);
		exec(`OP_WDT_CLR);
		rd("clear flags", `ADDR_STATUS, 8'h19);
	endtask
	initial
	begin
		repeat (3) @(posedge clk);
		reset <= 1'h0;
		tick(2);
		scnReset();
		scnAdd();
		scnSub();
		scnSkip();
		scnDaa();
		scnFlow();
		scnPages();
		scnMore();
		scnPower();
		printVerdict();
	end
endmodule
